// File: cid_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module cid_decoder (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [20:0] pc_next,
  input wire logic [3:0] bank_selector,
  input wire logic [7:0] working_accumulator,
  input wire logic [7:0] file_value,
  input wire logic cond_true,
  output cid_pkg::cid_dec_s dec,
  output logic dec_valid,
  output logic nop_cycle,
  output cid_pkg::cid_prod_s product,
  output logic product_valid
);

  function automatic cid_pkg::cid_op_e decode_op(input logic [15:0] iw);
    logic [3:0] nib;
    logic [1:0] sel;
    logic [2:0] sel3;
    cid_pkg::cid_op_e op;
    nib = iw[15:cid_pkg::IW_NIB_LO]; // RQ23
    sel = iw[11:10];
    sel3 = iw[11:9];
    op = cid_pkg::OP_CONTROL;
    case (nib)
      cid_pkg::NIB_MISC: begin
        if (iw[11]) begin
          op = cid_pkg::OP_LITERAL; // RQ6
        end else if (sel == cid_pkg::SEL_01) begin
          op = cid_pkg::OP_DECREMENT_FILE; // RQ14
        end else if (sel3 == cid_pkg::MUL_SEL) begin
          op = cid_pkg::OP_MULTIPLY_ACC_BY_FILE; // RQ17
        end
      end
      cid_pkg::NIB_LOGIC: begin
        case (sel) // RQ12
          cid_pkg::SEL_01: op = cid_pkg::OP_AND_ACC_WITH_FILE;
          cid_pkg::SEL_00: op = cid_pkg::OP_OR_ACC_WITH_FILE;
          cid_pkg::SEL_10: op = cid_pkg::OP_XOR_ACC_WITH_FILE;
          default: op = cid_pkg::OP_COMPLEMENT_FILE;
        endcase
      end
      cid_pkg::NIB_ADD: begin
        case (sel)
          cid_pkg::SEL_01: op = cid_pkg::OP_ADD_ACC_TO_FILE; // RQ11
          cid_pkg::SEL_00: op = cid_pkg::OP_ADD_ACC_CARRY_TO_FILE; // RQ11
          cid_pkg::SEL_10: op = cid_pkg::OP_INCREMENT_FILE; // RQ14
          default: op = cid_pkg::OP_DECREMENT_SKIP_ZERO; // RQ14
        endcase
      end
      cid_pkg::NIB_ROTC: begin
        case (sel)
          cid_pkg::SEL_01: op = cid_pkg::OP_ROTATE_LEFT_THRU_CARRY; // RQ15
          cid_pkg::SEL_00: op = cid_pkg::OP_ROTATE_RIGHT_THRU_CARRY; // RQ15
          cid_pkg::SEL_11: op = cid_pkg::OP_INCREMENT_SKIP_ZERO; // RQ14
          default: op = cid_pkg::OP_BYTE_OTHER;
        endcase
      end
      cid_pkg::NIB_ROTN: begin
        case (sel)
          cid_pkg::SEL_01: op = cid_pkg::OP_ROTATE_LEFT_PLAIN; // RQ15
          cid_pkg::SEL_00: op = cid_pkg::OP_ROTATE_RIGHT_PLAIN; // RQ15
          cid_pkg::SEL_11: op = cid_pkg::OP_DECREMENT_SKIP_NONZERO; // RQ14
          default: op = cid_pkg::OP_INCREMENT_SKIP_NONZERO; // RQ14
        endcase
      end
      cid_pkg::NIB_SUB: begin
        case (sel) // RQ16
          cid_pkg::SEL_11: op = cid_pkg::OP_SUB_ACC_FROM_FILE;
          cid_pkg::SEL_10: op = cid_pkg::OP_SUB_ACC_FROM_FILE_BORROW;
          cid_pkg::SEL_01: op = cid_pkg::OP_SUB_FILE_FROM_ACC_BORROW;
          default: op = cid_pkg::OP_BYTE_OTHER;
        endcase
      end
      cid_pkg::NIB_CMP: begin
        case (sel3) // RQ13
          cid_pkg::CMP_EQUAL: op = cid_pkg::OP_COMPARE_SKIP_EQUAL;
          cid_pkg::CMP_GREATER: op = cid_pkg::OP_COMPARE_SKIP_GREATER;
          cid_pkg::CMP_LESS: op = cid_pkg::OP_COMPARE_SKIP_LESS;
          default: op = cid_pkg::OP_BYTE_OTHER;
        endcase
      end
      cid_pkg::NIB_MOVE: op = cid_pkg::OP_MOVE_FILE_TO_FILE; // RQ4
      cid_pkg::NIB_REL: begin
        op = iw[11] ? cid_pkg::OP_REL_CALL : cid_pkg::OP_BRANCH_ALWAYS; // RQ8
      end
      cid_pkg::NIB_CTRL: begin
        if (!iw[11]) begin
          op = cid_pkg::OP_BRANCH_COND; // RQ9
        end else if (iw[11:9] == cid_pkg::CTRL_CALL[3:1]) begin
          op = cid_pkg::OP_CALL; // RQ7
        end else if (iw[11:8] == cid_pkg::CTRL_GOTO) begin
          op = cid_pkg::OP_GOTO; // RQ7
        end else if (iw[11:8] == cid_pkg::CTRL_PTR) begin
          op = cid_pkg::OP_LOAD_POINTER;
        end
      end
      cid_pkg::NIB_EXT: op = cid_pkg::OP_NOP; // RQ22
      default: op = cid_pkg::OP_BIT; // RQ5
    endcase
    return op;
  endfunction : decode_op

  function automatic logic [4:0] flag_mask(input cid_pkg::cid_op_e op);
    case (op)
      cid_pkg::OP_ADD_ACC_TO_FILE, cid_pkg::OP_ADD_ACC_CARRY_TO_FILE,
      cid_pkg::OP_DECREMENT_FILE, cid_pkg::OP_INCREMENT_FILE,
      cid_pkg::OP_SUB_ACC_FROM_FILE, cid_pkg::OP_SUB_ACC_FROM_FILE_BORROW,
      cid_pkg::OP_SUB_FILE_FROM_ACC_BORROW:
        return cid_pkg::FLAGS_ALL; // RQ11
      cid_pkg::OP_AND_ACC_WITH_FILE, cid_pkg::OP_OR_ACC_WITH_FILE,
      cid_pkg::OP_XOR_ACC_WITH_FILE, cid_pkg::OP_COMPLEMENT_FILE,
      cid_pkg::OP_ROTATE_LEFT_PLAIN, cid_pkg::OP_ROTATE_RIGHT_PLAIN:
        return cid_pkg::FLAGS_ZN; // RQ12
      cid_pkg::OP_ROTATE_LEFT_THRU_CARRY, cid_pkg::OP_ROTATE_RIGHT_THRU_CARRY:
        return cid_pkg::FLAGS_CZN; // RQ15
      default: return cid_pkg::FLAGS_NONE; // RQ13
    endcase
  endfunction : flag_mask

  function automatic logic two_word(input cid_pkg::cid_op_e op);
    return op == cid_pkg::OP_MOVE_FILE_TO_FILE || op == cid_pkg::OP_CALL ||
           op == cid_pkg::OP_GOTO || op == cid_pkg::OP_LOAD_POINTER;
  endfunction : two_word

  cid_pkg::cid_state_e st;
  cid_pkg::cid_state_e next_st;
  logic [15:0] held_word;
  cid_pkg::cid_dec_s next_dec;
  cid_pkg::cid_prod_s mult_out;
  logic [20:0] rel_out;

  wire in_first = st == cid_pkg::ST_FIRST;
  wire in_second = st == cid_pkg::ST_SECOND;
  wire in_flush = st == cid_pkg::ST_FLUSH;
  wire cid_pkg::cid_op_e first_op = decode_op(instr_word);
  wire first_two = two_word(first_op);
  wire [15:0] src_word = in_second ? held_word : instr_word;
  wire cid_pkg::cid_op_e src_op = decode_op(src_word);
  // A true test kills whatever word is fetched alongside it
  wire kill = instr_valid & ((in_first & cond_true) | in_flush); // RQ21
  wire issue = instr_valid & ((in_first & ~cond_true & ~first_two) | in_second);
  wire self_redirect = first_op == cid_pkg::OP_BRANCH_ALWAYS ||
                       first_op == cid_pkg::OP_REL_CALL;
  wire [3:0] op_nib = src_word[15:cid_pkg::IW_NIB_LO];
  wire byte_fmt = op_nib <= cid_pkg::NIB_CMP;
  wire bit_fmt = op_nib >= cid_pkg::NIB_BIT_LO && op_nib <= cid_pkg::NIB_BIT_HI;
  wire [7:0] f8 = src_word[cid_pkg::IW_FILE_HI:0]; // RQ3
  wire low_access = f8 < cid_pkg::ACCESS_SPLIT;
  wire [3:0] access_bank = low_access ? cid_pkg::BANK_LOW : cid_pkg::BANK_HIGH;
  wire bank_bit = src_word[cid_pkg::IW_BANK];
  wire [3:0] eff_bank = bank_bit ? bank_selector : access_bank; // RQ2
  wire is_move = src_op == cid_pkg::OP_MOVE_FILE_TO_FILE;
  wire [11:0] eff_addr = is_move ? src_word[cid_pkg::IW_ADDR_HI:0] : {eff_bank, f8}; // RQ4
  wire [11:0] move_dest = instr_word[cid_pkg::IW_ADDR_HI:0]; // RQ4
  wire dest_bit = src_word[cid_pkg::IW_DEST];
  wire no_dest = src_op == cid_pkg::OP_COMPARE_SKIP_EQUAL ||
                 src_op == cid_pkg::OP_COMPARE_SKIP_GREATER ||
                 src_op == cid_pkg::OP_COMPARE_SKIP_LESS ||
                 src_op == cid_pkg::OP_MULTIPLY_ACC_BY_FILE;
  // Compare group holds clear/set/move forms that always write the file
  wire cmp_writes = op_nib == cid_pkg::NIB_CMP && src_op == cid_pkg::OP_BYTE_OTHER;
  wire byte_writes = byte_fmt & ~no_dest & (dest_bit | cmp_writes); // RQ1
  wire bit_writes = bit_fmt & op_nib <= cid_pkg::NIB_BIT_WR_HI;
  wire file_write = byte_writes | bit_writes;
  wire in_ports = eff_addr >= cid_pkg::ADDR_PORT_FIRST &&
                  eff_addr <= cid_pkg::ADDR_PORT_LAST;
  wire wide_off = src_word[cid_pkg::IW_WIDE] == 1'b0 && op_nib == cid_pkg::NIB_REL;
  wire mul_issue = issue & src_op == cid_pkg::OP_MULTIPLY_ACC_BY_FILE;

  cid_mult u_mult (
    .working_accumulator(working_accumulator),
    .file_value(file_value),
    .product(mult_out)
  );

  cid_target u_target (
    .pc_next(pc_next),
    .word(src_word),
    .wide(wide_off | op_nib == cid_pkg::NIB_REL),
    .target(rel_out)
  );

  always_comb begin
    next_dec = '0;
    next_dec.op = issue ? src_op : cid_pkg::OP_NOP; // RQ22
    next_dec.dest_file = dest_bit; // RQ1
    next_dec.bank_access = bank_bit; // RQ2
    next_dec.file_addr = eff_addr;
    next_dec.dest_addr = in_second ? move_dest : '0;
    next_dec.bit_pos = src_word[cid_pkg::IW_BIT_HI:cid_pkg::IW_BIT_LO]; // RQ5
    next_dec.literal = src_word[cid_pkg::IW_FILE_HI:0]; // RQ6
    next_dec.flag_mask = issue ? flag_mask(src_op) : cid_pkg::FLAGS_NONE;
    next_dec.fast_return = src_word[cid_pkg::IW_FAST]; // RQ7
    next_dec.abs_target = {instr_word[cid_pkg::IW_ADDR_HI:0], held_word[7:0]}; // RQ7
    next_dec.rel_target = rel_out; // RQ10
    next_dec.port_rmw = issue & file_write & in_ports; // RQ19
    next_dec.clear_prescaler = issue & file_write &
                               eff_addr == cid_pkg::ADDR_TIMER_ZERO; // RQ20
  end

  always_comb begin
    next_st = st;
    unique case (st)
      cid_pkg::ST_FIRST: begin
        if (cond_true) begin
          next_st = instr_valid ? cid_pkg::ST_FIRST : cid_pkg::ST_FLUSH; // RQ21
        end else if (instr_valid & first_two) begin
          next_st = cid_pkg::ST_SECOND; // RQ4
        end else if (instr_valid & self_redirect) begin
          next_st = cid_pkg::ST_FLUSH; // RQ21
        end
      end
      cid_pkg::ST_SECOND: begin
        if (instr_valid) begin
          next_st = cid_pkg::ST_FIRST;
        end
      end
      cid_pkg::ST_FLUSH: begin
        if (instr_valid) begin
          next_st = cid_pkg::ST_FIRST;
        end
      end
      default: next_st = cid_pkg::ST_FIRST;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= cid_pkg::ST_FIRST;
      held_word <= '0;
    end else begin
      st <= next_st;
      if (instr_valid & in_first & first_two & ~cond_true) begin
        held_word <= instr_word;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dec <= '0;
      dec_valid <= 1'b0;
      nop_cycle <= 1'b0;
    end else begin
      dec <= next_dec;
      dec_valid <= issue | kill;
      nop_cycle <= kill; // RQ21
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      product <= '0;
      product_valid <= 1'b0;
    end else begin
      product_valid <= mul_issue;
      if (mul_issue) begin
        product <= mult_out; // RQ18
      end
    end
  end

  wire first_take = instr_valid & in_first & ~cond_true;
  wire [3:0] in_nib = instr_word[15:cid_pkg::IW_NIB_LO];

  property p_dest;
    @(posedge clk) disable iff (!reset_n)
      first_take && in_nib == cid_pkg::NIB_ADD |=>
      dec.dest_file == $past(instr_word[cid_pkg::IW_DEST]);
  endproperty
  a_dest: assert property (p_dest) else $error("destination bit lost"); // RQ1

  property p_bank;
    @(posedge clk) disable iff (!reset_n)
      first_take && in_nib == cid_pkg::NIB_LOGIC && instr_word[cid_pkg::IW_BANK] |=>
      dec.file_addr[11:8] == $past(bank_selector);
  endproperty
  a_bank: assert property (p_bank) else $error("bank selector not used"); // RQ2

  property p_move;
    @(posedge clk) disable iff (!reset_n)
      first_take && in_nib == cid_pkg::NIB_MOVE ##1 instr_valid |=>
      dec_valid && dec.op == cid_pkg::OP_MOVE_FILE_TO_FILE &&
      dec.file_addr == $past(instr_word[11:0], 2) &&
      dec.dest_addr == $past(instr_word[11:0]);
  endproperty
  a_move: assert property (p_move) else $error("file move misassembled"); // RQ4

  property p_abs;
    @(posedge clk) disable iff (!reset_n)
      first_take && first_op == cid_pkg::OP_GOTO ##1 instr_valid |=>
      dec.op == cid_pkg::OP_GOTO &&
      dec.abs_target == {$past(instr_word[11:0]), $past(instr_word[7:0], 2)};
  endproperty
  a_abs: assert property (p_abs) else $error("absolute target wrong"); // RQ7

  property p_arith_flags;
    @(posedge clk) disable iff (!reset_n)
      first_take && in_nib == cid_pkg::NIB_SUB && instr_word[11:10] != 2'h0 |=>
      dec.flag_mask == cid_pkg::FLAGS_ALL;
  endproperty
  a_arith_flags: assert property (p_arith_flags) else $error("arith flags"); // RQ16

  property p_logic_flags;
    @(posedge clk) disable iff (!reset_n)
      first_take && in_nib == cid_pkg::NIB_LOGIC |=>
      dec_valid && !nop_cycle && dec.flag_mask == cid_pkg::FLAGS_ZN;
  endproperty
  a_logic_flags: assert property (p_logic_flags) else $error("logic flags"); // RQ12

  property p_branch_nop;
    @(posedge clk) disable iff (!reset_n)
      first_take && first_op == cid_pkg::OP_BRANCH_ALWAYS ##1 instr_valid |=>
      nop_cycle && dec.op == cid_pkg::OP_NOP;
  endproperty
  a_branch_nop: assert property (p_branch_nop) else $error("no bubble"); // RQ21

  property p_mul;
    @(posedge clk) disable iff (!reset_n)
      first_take && first_op == cid_pkg::OP_MULTIPLY_ACC_BY_FILE |=>
      dec.flag_mask == cid_pkg::FLAGS_NONE && product_valid &&
      product == $past(16'(working_accumulator) * 16'(file_value));
  endproperty
  a_mul: assert property (p_mul) else $error("multiply wrong"); // RQ17

  property p_orphan;
    @(posedge clk) disable iff (!reset_n)
      first_take && in_nib == cid_pkg::NIB_EXT |=>
      dec.op == cid_pkg::OP_NOP && !dec.clear_prescaler;
  endproperty
  a_orphan: assert property (p_orphan) else $error("orphan word acted"); // RQ22

endmodule : cid_decoder
`default_nettype wire

// File: cid_mult.sv
`timescale 1ns/100ps
`default_nettype none
module cid_mult (
  input wire logic [7:0] working_accumulator,
  input wire logic [7:0] file_value,
  output cid_pkg::cid_prod_s product
);
  logic [15:0] full;
  // Unsigned 8x8, whole product in one cycle
  assign full = 16'(working_accumulator) * 16'(file_value);
  assign product.high = full[15:8]; // RQ18
  assign product.low = full[7:0]; // RQ18
endmodule : cid_mult
`default_nettype wire

// File: cid_pkg.sv
// Operation
// [RQ1] Destination bit 0 sends result to accumulator, 1 to file register
// [RQ2] Bank-access bit 0 forces access bank, 1 uses bank selector
// [RQ3] Byte and bit formats carry 8-bit file address in low byte
// [RQ4] Two-word file move: 12-bit source, then 1111-prefixed 12-bit destination
// [RQ5] Bit formats decode a 3-bit bit position field
// [RQ6] Literal formats take 8-bit immediate from low byte
// [RQ7] Absolute call/jump build 20-bit target from two words; call has fast bit
// [RQ8] Unconditional relative branch carries 11-bit offset in low bits
// [RQ9] Conditional relative branches carry 8-bit offset in low byte
// [RQ10] Relative offsets are signed two's complement added to program counter
// [RQ11] Decode add and add-with-carry; one cycle, all five arithmetic flags
// [RQ12] Decode and, or, xor, complement; one cycle, zero and negative only
// [RQ13] Decode three compare-and-skip forms; no flags changed
// [RQ14] Decode decrement, increment with flags; skip-on-result forms change no flag
// [RQ15] Rotates through carry touch C, Z, N; plain rotates Z, N only
// [RQ16] Decode three subtract forms; all arithmetic flags updated
// [RQ17] Decode single-cycle unsigned multiply; no flags affected
// [RQ18] Multiply yields 16-bit product split into high and low bytes
// [RQ19] Port read-modify-write uses pin levels as source value
// [RQ20] Writing timer zero clears its assigned prescaler
// [RQ21] Program counter change or true test costs a second no-operation cycle
// [RQ22] Orphan second words execute as no-operation
// [RQ23] Bit 15 is the top bit; opcode nibbles matched from the top
package cid_pkg;
  localparam int IW_NIB_LO = 12;
  localparam int IW_DEST = 9;
  localparam int IW_BANK = 8;
  localparam int IW_FAST = 8;
  localparam int IW_FILE_HI = 7;
  localparam int IW_ADDR_HI = 11;
  localparam int IW_BIT_HI = 11;
  localparam int IW_BIT_LO = 9;
  localparam int IW_N11_HI = 10;
  localparam int IW_WIDE = 11;
  localparam logic [3:0] NIB_MISC = 4'h0;
  localparam logic [3:0] NIB_LOGIC = 4'h1;
  localparam logic [3:0] NIB_ADD = 4'h2;
  localparam logic [3:0] NIB_ROTC = 4'h3;
  localparam logic [3:0] NIB_ROTN = 4'h4;
  localparam logic [3:0] NIB_SUB = 4'h5;
  localparam logic [3:0] NIB_CMP = 4'h6;
  localparam logic [3:0] NIB_BIT_LO = 4'h7;
  localparam logic [3:0] NIB_BIT_WR_HI = 4'h9;
  localparam logic [3:0] NIB_BIT_HI = 4'hb;
  localparam logic [3:0] NIB_MOVE = 4'hc;
  localparam logic [3:0] NIB_REL = 4'hd;
  localparam logic [3:0] NIB_CTRL = 4'he;
  localparam logic [3:0] NIB_EXT = 4'hf;
  localparam logic [1:0] SEL_00 = 2'h0;
  localparam logic [1:0] SEL_01 = 2'h1;
  localparam logic [1:0] SEL_10 = 2'h2;
  localparam logic [1:0] SEL_11 = 2'h3;
  localparam logic [2:0] CMP_LESS = 3'h0;
  localparam logic [2:0] CMP_EQUAL = 3'h1;
  localparam logic [2:0] CMP_GREATER = 3'h2;
  localparam logic [2:0] MUL_SEL = 3'h1;
  localparam logic [3:0] CTRL_CALL = 4'hc;
  localparam logic [3:0] CTRL_PTR = 4'he;
  localparam logic [3:0] CTRL_GOTO = 4'hf;
  // Flag order: carry, digit carry, zero, overflow, negative
  localparam logic [4:0] FLAGS_ALL = 5'h1f;
  localparam logic [4:0] FLAGS_CZN = 5'h15;
  localparam logic [4:0] FLAGS_ZN = 5'h05;
  localparam logic [4:0] FLAGS_NONE = 5'h00;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] BANK_LOW = 4'h0;
  localparam logic [3:0] BANK_HIGH = 4'hf;
  localparam logic [11:0] ADDR_TIMER_ZERO = 12'hfd6;
  localparam logic [11:0] ADDR_PORT_FIRST = 12'hf80;
  localparam logic [11:0] ADDR_PORT_LAST = 12'hf84;
  typedef enum logic [5:0] {
    OP_NOP, OP_ADD_ACC_TO_FILE, OP_ADD_ACC_CARRY_TO_FILE,
    OP_AND_ACC_WITH_FILE, OP_OR_ACC_WITH_FILE, OP_XOR_ACC_WITH_FILE,
    OP_COMPLEMENT_FILE, OP_COMPARE_SKIP_EQUAL, OP_COMPARE_SKIP_GREATER,
    OP_COMPARE_SKIP_LESS, OP_DECREMENT_FILE, OP_DECREMENT_SKIP_ZERO,
    OP_DECREMENT_SKIP_NONZERO, OP_INCREMENT_FILE, OP_INCREMENT_SKIP_ZERO,
    OP_INCREMENT_SKIP_NONZERO, OP_ROTATE_LEFT_THRU_CARRY,
    OP_ROTATE_RIGHT_THRU_CARRY, OP_ROTATE_LEFT_PLAIN, OP_ROTATE_RIGHT_PLAIN,
    OP_SUB_ACC_FROM_FILE, OP_SUB_ACC_FROM_FILE_BORROW,
    OP_SUB_FILE_FROM_ACC_BORROW, OP_MULTIPLY_ACC_BY_FILE,
    OP_MOVE_FILE_TO_FILE, OP_BYTE_OTHER, OP_BIT, OP_LITERAL,
    OP_BRANCH_ALWAYS, OP_REL_CALL, OP_BRANCH_COND, OP_CALL, OP_GOTO,
    OP_LOAD_POINTER, OP_CONTROL
  } cid_op_e;
  typedef enum logic [1:0] {
    ST_FIRST = 2'b00,
    ST_SECOND = 2'b01,
    ST_FLUSH = 2'b10
  } cid_state_e;
  typedef struct packed {
    cid_op_e op;
    logic dest_file;
    logic bank_access;
    logic [11:0] file_addr;
    logic [11:0] dest_addr;
    logic [2:0] bit_pos;
    logic [7:0] literal;
    logic [4:0] flag_mask;
    logic fast_return;
    logic [19:0] abs_target;
    logic [20:0] rel_target;
    logic port_rmw;
    logic clear_prescaler;
  } cid_dec_s;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } cid_prod_s;
endpackage : cid_pkg

// File: cid_prog_mem.sv
`timescale 1ns/100ps
`default_nettype none
module cid_prog_mem (
  input wire logic clk,
  input wire logic start,
  input wire logic [4:0] len,
  output logic instr_valid,
  output logic [15:0] instr_word,
  output logic [20:0] pc_next
);
  logic [15:0] mem [0:15];
  logic [4:0] ptr;
  logic [4:0] left;
  initial begin
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    pc_next = 21'h000000;
    ptr = 5'h00;
    left = 5'h00;
  end
  // Fetch stream: one word a cycle from location 0 after each start
  always @(negedge clk) begin
    if (start) begin
      ptr <= 5'h00;
      left <= len;
      instr_valid <= 1'b0;
    end else if (left != 5'h00) begin
      instr_valid <= 1'b1;
      instr_word <= mem[ptr[3:0]];
      pc_next <= {15'h0000, ptr + 5'h01, 1'b0};
      ptr <= ptr + 5'h01;
      left <= left - 5'h01;
    end else begin
      // Idle bus must not look like a repeated word
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
    end
  end
endmodule : cid_prog_mem
`default_nettype wire

// File: cid_target.sv
`timescale 1ns/100ps
`default_nettype none
module cid_target (
  input wire logic [20:0] pc_next,
  input wire logic [15:0] word,
  input wire logic wide,
  output logic [20:0] target
);
  logic [20:0] off_wide;
  logic [20:0] off_narrow;
  logic [20:0] step;
  // Offsets count words, program counter counts bytes
  assign off_wide = {{9{word[cid_pkg::IW_N11_HI]}}, word[cid_pkg::IW_N11_HI:0], 1'b0}; // RQ8
  assign off_narrow = {{12{word[cid_pkg::IW_FILE_HI]}}, word[cid_pkg::IW_FILE_HI:0], 1'b0}; // RQ9
  assign step = wide ? off_wide : off_narrow;
  assign target = pc_next + step; // RQ10
endmodule : cid_target
`default_nettype wire

// File: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk, reset_n, start, cond_true, ivalid, dec_valid, nop_cycle, pvalid, saw_prod, last_nop;
  logic [4:0] len;
  logic [15:0] iword;
  logic [20:0] pc_next;
  logic [3:0] bank_selector;
  logic [7:0] acc, fval;
  cid_pkg::cid_dec_s dec, d;
  cid_pkg::cid_prod_s product;
  cid_pkg::cid_dec_s got_q[$];
  logic nop_q[$];
  int err_total, checks, cyc;
  // Byte ops in the enum's own order, starting at the logic group
  logic [15:0] bw [21] = '{16'h1600, 16'h1300, 16'h1a00, 16'h1e00, 16'h6200, 16'h6400,
    16'h6000, 16'h0600, 16'h2e00, 16'h4e00, 16'h2a00, 16'h3e00, 16'h4a00, 16'h3600,
    16'h3200, 16'h4600, 16'h4200, 16'h5e00, 16'h5a00, 16'h5600, 16'h0200};
  logic [4:0] bm [21] = '{5'h05, 5'h05, 5'h05, 5'h05, 5'h00, 5'h00, 5'h00, 5'h1f, 5'h00,
    5'h00, 5'h1f, 5'h00, 5'h00, 5'h15, 5'h15, 5'h05, 5'h05, 5'h1f, 5'h1f, 5'h1f, 5'h00};
  cid_prog_mem pm (.clk(clk), .start(start), .len(len), .instr_valid(ivalid),
    .instr_word(iword), .pc_next(pc_next));
  cid_decoder dut (.clk(clk), .reset_n(reset_n), .instr_valid(ivalid), .instr_word(iword),
    .pc_next(pc_next), .bank_selector(bank_selector), .working_accumulator(acc),
    .file_value(fval), .cond_true(cond_true), .dec(dec), .dec_valid(dec_valid),
    .nop_cycle(nop_cycle), .product(product), .product_valid(pvalid));
  always #5 clk = ~clk;
  always @(negedge clk) begin
    if (dec_valid === 1'b1) begin
      got_q.push_back(dec);
      nop_q.push_back(nop_cycle);
    end
    if (pvalid === 1'b1) saw_prod <= 1'b1;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic [15:0] w0, w1, w2, w3, input logic [4:0] n);
    got_q.delete();
    nop_q.delete();
    pm.mem[0] = w0;
    pm.mem[1] = w1;
    pm.mem[2] = w2;
    pm.mem[3] = w3;
    @(negedge clk);
    start <= 1'b1;
    len <= n;
    @(negedge clk);
    start <= 1'b0;
    repeat (n + 5) @(negedge clk);
  endtask : run
  task automatic pop;
    d = '0;
    last_nop = 1'b0;
    chk(got_q.size() != 0, 1);
    if (got_q.size() != 0) begin
      d = got_q.pop_front();
      last_nop = nop_q.pop_front();
    end
  endtask : pop
  task automatic give_verdict;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    start = 1'b0;
    len = 5'h00;
    cond_true = 1'b0;
    bank_selector = 4'h5;
    acc = 8'hff;
    fval = 8'hfe;
    saw_prod = 1'b0;
    err_total = 0;
    checks = 0;
    cyc = 0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    run(16'h2601, 16'h2305, 16'h2401, 16'h0000, 5'h03);
    pop();
    chk(d.op, cid_pkg::OP_ADD_ACC_TO_FILE);
    chk({d.dest_file, d.bank_access, d.file_addr}, {2'h2, 12'h001});
    pop();
    chk(d.op, cid_pkg::OP_ADD_ACC_CARRY_TO_FILE);
    chk({d.bank_access, d.file_addr}, {1'b1, 12'h505});
    pop();
    chk(d.dest_file, 0);
    $display("test addressing done");
    for (int i = 0; i < 21; i++) begin
      run(bw[i], 16'h0000, 16'h0000, 16'h0000, 5'h01);
      pop();
      chk(d.op, cid_pkg::OP_AND_ACC_WITH_FILE + i);
      chk(d.flag_mask, bm[i]);
    end
    chk(saw_prod, 1);
    chk(product, 16'hfd02);
    $display("test byte ops done");
    run(16'hc123, 16'hf456, 16'hf789, 16'h0000, 5'h03);
    pop();
    chk({d.op, d.file_addr, d.dest_addr}, {cid_pkg::OP_MOVE_FILE_TO_FILE, 24'h123456});
    pop();
    chk(d.op, cid_pkg::OP_NOP);
    chk(got_q.size(), 0);
    $display("test move done");
    // Fifth word soaks up the bubble after the last branch
    pm.mem[4] = 16'h2601;
    run(16'hd005, 16'h2601, 16'he2fe, 16'hd7ff, 5'h05);
    pop();
    chk({d.op, d.rel_target}, {cid_pkg::OP_BRANCH_ALWAYS, 21'h00000c});
    pop();
    chk({last_nop, d.op}, {1'b1, cid_pkg::OP_NOP});
    pop();
    chk({d.op, d.rel_target}, {cid_pkg::OP_BRANCH_COND, 21'h000002});
    pop();
    chk(d.rel_target, 21'h000006);
    pop();
    chk({last_nop, d.op}, {1'b1, cid_pkg::OP_NOP});
    // True test with no word fetched: the next word becomes the bubble
    @(negedge clk);
    cond_true <= 1'b1;
    @(negedge clk);
    cond_true <= 1'b0;
    run(16'h2601, 16'h2305, 16'h0000, 16'h0000, 5'h02);
    pop();
    chk({last_nop, d.op}, {1'b1, cid_pkg::OP_NOP});
    pop();
    chk({last_nop, d.op}, {1'b0, cid_pkg::OP_ADD_ACC_CARRY_TO_FILE});
    $display("test branch done");
    run(16'hef34, 16'hf123, 16'hed56, 16'hfabc, 5'h04);
    pop();
    chk({d.op, d.abs_target}, {cid_pkg::OP_GOTO, 20'h12334});
    pop();
    chk({d.op, d.fast_return, d.abs_target}, {cid_pkg::OP_CALL, 21'h1abc56});
    run(16'h9b12, 16'h0f7f, 16'h0000, 16'h0000, 5'h02);
    pop();
    chk({d.op, d.bit_pos, d.file_addr}, {cid_pkg::OP_BIT, 3'h5, 12'h512});
    pop();
    chk({d.op, d.literal}, {cid_pkg::OP_LITERAL, 8'h7f});
    run(16'h2ad6, 16'h28d6, 16'h2a80, 16'h2601, 5'h04);
    pop();
    chk({d.file_addr, d.clear_prescaler}, {12'hfd6, 1'b1});
    pop();
    chk(d.clear_prescaler, 0);
    pop();
    chk({d.file_addr, d.port_rmw}, {12'hf80, 1'b1});
    pop();
    chk({d.port_rmw, d.clear_prescaler}, 0);
    $display("test formats done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
